// ===== scr_evt_irq.sv
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_evt_irq (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire scr_pkg::scr_evt_t i_evt,
  input  wire logic             i_clr_we,
  input  wire logic             i_en_we,
  input  wire scr_pkg::scr_evt_t i_wdata,
  output scr_pkg::scr_evt_t      o_status_nxt,
  output scr_pkg::scr_evt_t      o_enable_nxt,
  output logic                  o_irq
);
  import scr_pkg::*;

  scr_evt_t status_r;
  scr_evt_t enable_r;
  scr_evt_t clr_mask;

  // an event in the clearing cycle survives the clear
  assign clr_mask     = i_clr_we ? i_wdata : `SCR_EVT_RST;
  assign o_status_nxt = i_evt | (status_r & ~clr_mask);
  assign o_enable_nxt = i_en_we ? i_wdata : enable_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_r <= `SCR_EVT_RST;
      enable_r <= `SCR_EVT_RST;
      o_irq    <= 1'b0;
    end else begin
      status_r <= o_status_nxt;
      enable_r <= o_enable_nxt;
      o_irq    <= |(o_status_nxt & o_enable_nxt);
    end
  end

  AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_irq == |(status_r & enable_r))
    else $error("interrupt level does not follow enabled status");
endmodule

// ===== scr_map.svh
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, low bits of haddr)
// ----------------------------------------------------------------
`define SCR_ADDR_W        12
`define SCR_OFS_IDENT     12'h000
`define SCR_OFS_INTERRUPT_CONTROL_STATE      12'h004
`define SCR_OFS_AUX       12'h008
`define SCR_OFS_IRQ_STAT  12'h010
`define SCR_OFS_IRQ_CLR   12'h014
`define SCR_OFS_IRQ_EN    12'h018

// ----------------------------------------------------------------
// auxiliary control fields
// ----------------------------------------------------------------
`define SCR_AUX_FPOOO     9
`define SCR_AUX_DUAL      2
`define SCR_AUX_MCYC      0
`define SCR_AUX_RST       1'b0

// ----------------------------------------------------------------
// identification fields
// ----------------------------------------------------------------
`define SCR_ID_CONST      4'hf

// ----------------------------------------------------------------
// interrupt control and state fields
// ----------------------------------------------------------------
`define SCR_INTERRUPT_CONTROL_STATE_NMI_SET  31
`define SCR_INTERRUPT_CONTROL_STATE_NMI_CLR  30
`define SCR_INTERRUPT_CONTROL_STATE_SVC_SET  28
`define SCR_INTERRUPT_CONTROL_STATE_SVC_CLR  27
`define SCR_INTERRUPT_CONTROL_STATE_TCK_SET  26
`define SCR_INTERRUPT_CONTROL_STATE_TCK_CLR  25
`define SCR_INTERRUPT_CONTROL_STATE_ISRP     22
`define SCR_INTERRUPT_CONTROL_STATE_VPEND_LO 12
`define SCR_INTERRUPT_CONTROL_STATE_RETBASE  11

// ----------------------------------------------------------------
// event status layout
// ----------------------------------------------------------------
`define SCR_EVT_W         3
`define SCR_EVT_NMI       0
`define SCR_EVT_SVC       1
`define SCR_EVT_TCK       2
`define SCR_EVT_RST       3'h0

`endif

// ===== scr_pkg.sv
package scr_pkg;
  typedef logic [31:0] scr_word_t;
  typedef logic [8:0]  scr_vec_t;
  typedef logic [1:0]  scr_bank_t;
  typedef logic [2:0]  scr_evt_t;
endpackage

// ===== scr_top.sv
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_top #(
  parameter logic [7:0]  IMPLEMENTER = 8'h5a,  // arbitrary value
  parameter logic [3:0]  VARIANT     = 4'h1,   // arbitrary value
  parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
  parameter logic [3:0]  PATCH       = 4'h3    // arbitrary value
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_hsel,
  input  wire scr_pkg::scr_word_t i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire scr_pkg::scr_word_t i_hwdata,
  input  wire logic              i_hready,
  input  wire logic              i_hnonsec,
  input  wire logic              i_nmi_req,
  input  wire logic              i_nmi_taken,
  input  wire scr_pkg::scr_bank_t i_svc_taken,
  input  wire scr_pkg::scr_bank_t i_tick_req,
  input  wire scr_pkg::scr_bank_t i_tick_taken,
  input  wire scr_pkg::scr_vec_t  i_active_vector,
  input  wire scr_pkg::scr_vec_t  i_pending_vector,
  input  wire logic              i_preempted_active,
  input  wire logic              i_isr_pending,
  output scr_pkg::scr_word_t      o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  output logic                   o_fp_out_of_order_disable,
  output logic                   o_dual_issue_disable,
  output logic                   o_multicycle_interrupt_disable,
  output logic                   o_nmi_pending,
  output scr_pkg::scr_bank_t      o_service_call_pending,
  output scr_pkg::scr_bank_t      o_tick_pending,
  output logic                   o_irq
);
  import scr_pkg::*;

  // ----------------------------------------------------------------
  // bus address and data phase
  // ----------------------------------------------------------------
  logic                     dp_valid_r;
  logic                     dp_write_r;
  logic                     dp_nonsec_r;
  logic [`SCR_ADDR_W-1:0]   dp_addr_r;
  logic                     ap_valid;
  logic                     ap_read;
  logic [`SCR_ADDR_W-1:0]   ap_addr;
  logic                     wr_en;

  // only NONSEQ/SEQ with the bus ready start a transfer; hsize is not
  // checked since the master only issues whole words
  assign ap_valid = i_hsel & i_htrans[1] & i_hready;
  assign ap_read  = ap_valid & ~i_hwrite;
  assign ap_addr  = i_haddr[`SCR_ADDR_W-1:0];
  assign wr_en    = dp_valid_r & dp_write_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dp_valid_r  <= 1'b0;
      dp_write_r  <= 1'b0;
      dp_nonsec_r <= 1'b0;
      dp_addr_r   <= '0;
    end else begin
      dp_valid_r  <= ap_valid;
      dp_write_r  <= i_hwrite;
      dp_nonsec_r <= i_hnonsec;
      dp_addr_r   <= ap_addr;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_aux;
  logic wr_interrupt_control_state;
  logic wr_irq_clr;
  logic wr_irq_en;

  // identification and status writes decode to nothing: ignored
  assign wr_aux     = wr_en & (dp_addr_r == `SCR_OFS_AUX);
  assign wr_interrupt_control_state    = wr_en & (dp_addr_r == `SCR_OFS_INTERRUPT_CONTROL_STATE);
  assign wr_irq_clr = wr_en & (dp_addr_r == `SCR_OFS_IRQ_CLR);
  assign wr_irq_en  = wr_en & (dp_addr_r == `SCR_OFS_IRQ_EN);

  // ----------------------------------------------------------------
  // auxiliary control
  // ----------------------------------------------------------------
  logic fpooo_nxt;
  logic dual_nxt;
  logic mcyc_nxt;

  assign fpooo_nxt = wr_aux ? i_hwdata[`SCR_AUX_FPOOO] : o_fp_out_of_order_disable;
  assign dual_nxt  = wr_aux ? i_hwdata[`SCR_AUX_DUAL] : o_dual_issue_disable;
  assign mcyc_nxt  = wr_aux ? i_hwdata[`SCR_AUX_MCYC]
                            : o_multicycle_interrupt_disable;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fp_out_of_order_disable      <= `SCR_AUX_RST;
      o_dual_issue_disable           <= `SCR_AUX_RST;
      o_multicycle_interrupt_disable <= `SCR_AUX_RST;
    end else begin
      o_fp_out_of_order_disable      <= fpooo_nxt;
      o_dual_issue_disable           <= dual_nxt;
      o_multicycle_interrupt_disable <= mcyc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // nmi pending, shared by both security states
  // ----------------------------------------------------------------
  logic nmi_set;
  logic nmi_clr;
  logic nmi_nxt;

  assign nmi_set = i_nmi_req | (wr_interrupt_control_state & i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_NMI_SET]);
  assign nmi_clr = i_nmi_taken | (wr_interrupt_control_state & i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_NMI_CLR]);
  // set beats clear so a request in the clearing cycle is never lost
  assign nmi_nxt = nmi_set | (o_nmi_pending & ~nmi_clr);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_nmi_pending <= 1'b0;
    end else begin
      o_nmi_pending <= nmi_nxt;
    end
  end

  // ----------------------------------------------------------------
  // banked service call and tick pending, index 1 is non-secure
  // ----------------------------------------------------------------
  scr_bank_t svc_nxt;
  scr_bank_t tck_nxt;

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_bank
      logic bank_wr;
      logic svc_set;
      logic svc_clr;
      logic tck_set;
      logic tck_clr;

      // each access touches only the copy of its own security state
      assign bank_wr = wr_interrupt_control_state & (dp_nonsec_r == 1'(b));
      assign svc_set = bank_wr & i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_SVC_SET];
      assign svc_clr = i_svc_taken[b] | (bank_wr & i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_SVC_CLR]);
      assign tck_set = i_tick_req[b] | (bank_wr & i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_TCK_SET]);
      assign tck_clr = i_tick_taken[b] | (bank_wr & i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_TCK_CLR]);
      assign svc_nxt[b] = svc_set | (o_service_call_pending[b] & ~svc_clr);
      assign tck_nxt[b] = tck_set | (o_tick_pending[b] & ~tck_clr);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_service_call_pending <= '0;
      o_tick_pending         <= '0;
    end else begin
      o_service_call_pending <= svc_nxt;
      o_tick_pending         <= tck_nxt;
    end
  end

  // ----------------------------------------------------------------
  // event status and interrupt
  // ----------------------------------------------------------------
  scr_evt_t evt;
  scr_evt_t irq_status_nxt;
  scr_evt_t irq_enable_nxt;

  assign evt[`SCR_EVT_NMI] = nmi_nxt & ~o_nmi_pending;
  assign evt[`SCR_EVT_SVC] = |(svc_nxt & ~o_service_call_pending);
  assign evt[`SCR_EVT_TCK] = |(tck_nxt & ~o_tick_pending);

  scr_evt_irq u_evt_irq (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_evt        (evt),
    .i_clr_we     (wr_irq_clr),
    .i_en_we      (wr_irq_en),
    .i_wdata      (i_hwdata[`SCR_EVT_W-1:0]),
    .o_status_nxt (irq_status_nxt),
    .o_enable_nxt (irq_enable_nxt),
    .o_irq        (o_irq)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  scr_word_t id_word;
  scr_word_t interrupt_control_state_word;
  scr_word_t aux_word;
  scr_word_t rd_sel;
  logic      ap_bank;
  logic      svc_rd;
  logic      tck_rd;

  // read data comes from next-state values so a read right behind a
  // write sees it without a wait state
  assign ap_bank = i_hnonsec;
  assign svc_rd  = ap_bank ? svc_nxt[1] : svc_nxt[0];
  assign tck_rd  = ap_bank ? tck_nxt[1] : tck_nxt[0];

  // not banked: identical for both security states
  assign id_word = {IMPLEMENTER, VARIANT,
                    `SCR_ID_CONST, PART_NUMBER,
                    PATCH};

  // clear bits, reserved and debug bits read zero
  assign interrupt_control_state_word = {nmi_nxt, 2'b00, svc_rd, 1'b0, tck_rd, 3'b000,
                      i_isr_pending, 1'b0, i_pending_vector,
                      ~i_preempted_active, 2'b00, i_active_vector};

  assign aux_word = {22'h0, fpooo_nxt, 6'h00, dual_nxt, 1'b0, mcyc_nxt};

  always_comb begin
    case (ap_addr)
      `SCR_OFS_IDENT:    rd_sel = id_word;
      `SCR_OFS_INTERRUPT_CONTROL_STATE:     rd_sel = interrupt_control_state_word;
      `SCR_OFS_AUX:      rd_sel = aux_word;
      `SCR_OFS_IRQ_STAT: rd_sel = {29'h0, irq_status_nxt};
      `SCR_OFS_IRQ_EN:   rd_sel = {29'h0, irq_enable_nxt};
      default:           rd_sel = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hrdata    <= ap_read ? rd_sel : 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_wr(logic [`SCR_ADDR_W-1:0] a);
    dp_valid_r && dp_write_r && dp_addr_r == a;
  endsequence

  sequence s_rd(logic [`SCR_ADDR_W-1:0] a);
    ap_read && ap_addr == a;
  endsequence

  AST_FPOOO_WRITE: assert property (
    s_wr(`SCR_OFS_AUX) |=> o_fp_out_of_order_disable == $past(i_hwdata[`SCR_AUX_FPOOO]))
    else $error("out-of-order disable did not take the written value");

  AST_DUAL_HOLD: assert property (
    !wr_aux |=> $stable(o_dual_issue_disable))
    else $error("dual issue disable changed without a write");

  AST_MCYC_WRITE: assert property (
    s_wr(`SCR_OFS_AUX) ##1 !wr_aux [*2] |-> o_multicycle_interrupt_disable
      == $past(i_hwdata[`SCR_AUX_MCYC], 2))
    else $error("multi-cycle interrupt disable lost its value");

  AST_ID_FIXED: assert property (
    s_rd(`SCR_OFS_IDENT) |=> o_hrdata == {IMPLEMENTER, VARIANT, 4'hf, PART_NUMBER, PATCH})
    else $error("identification read wrong in some security state");

  AST_NMI_SET: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_NMI_SET] |=> o_nmi_pending [*1])
    else $error("nmi not pending after set write");

  AST_NMI_CLR: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 (i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_NMI_CLR] && !i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_NMI_SET]
      && !i_nmi_req) |=> !o_nmi_pending)
    else $error("nmi still pending after clear write");

  AST_SVC_BANK: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 (i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_SVC_SET] && dp_nonsec_r)
      |=> o_service_call_pending[1])
    else $error("non-secure service call set missed its bank");

  AST_TICK_CLR: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 (i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_TCK_CLR] && !i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_TCK_SET]
      && !dp_nonsec_r && !i_tick_req[0]) |=> !o_tick_pending[0])
    else $error("secure tick pending survived clear");

  AST_RET_BASE: assert property (
    s_rd(`SCR_OFS_INTERRUPT_CONTROL_STATE) |=> o_hrdata[`SCR_INTERRUPT_CONTROL_STATE_RETBASE] == !$past(i_preempted_active))
    else $error("return-to-base flag wrong");

  AST_VPEND: assert property (
    s_rd(`SCR_OFS_INTERRUPT_CONTROL_STATE) |=> o_hrdata[20:12] == $past(i_pending_vector))
    else $error("pending vector field wrong");

  AST_RSV_ZERO: assert property (
    s_rd(`SCR_OFS_INTERRUPT_CONTROL_STATE) |=> o_hrdata[30:29] == 2'b00 && o_hrdata[10:9] == 2'b00
      && o_hrdata[21] == 1'b0)
    else $error("reserved interrupt control bits not zero");

  AST_SVC_CLR: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 (i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_SVC_CLR] && !i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_SVC_SET]
      && dp_nonsec_r) |=> !o_service_call_pending[1])
    else $error("non-secure service call pending survived clear");

  AST_TICK_SET: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 (i_hwdata[`SCR_INTERRUPT_CONTROL_STATE_TCK_SET] && dp_nonsec_r)
      |=> o_tick_pending[1])
    else $error("non-secure tick set missed its bank");

  AST_BANK_KEEP: assert property (
    s_wr(`SCR_OFS_INTERRUPT_CONTROL_STATE) ##0 (!dp_nonsec_r && !i_svc_taken[1])
      |=> $stable(o_service_call_pending[1]))
    else $error("secure write changed the non-secure service call copy");

  AST_ACTIVE_VEC: assert property (
    s_rd(`SCR_OFS_INTERRUPT_CONTROL_STATE) |=> o_hrdata[8:0] == $past(i_active_vector)
      && o_hrdata[`SCR_INTERRUPT_CONTROL_STATE_ISRP] == $past(i_isr_pending))
    else $error("active vector or interrupt pending flag wrong");

  AST_AUX_RSV: assert property (
    s_rd(`SCR_OFS_AUX) |=> (o_hrdata & 32'hffff_fdfa) == 32'h0000_0000)
    else $error("reserved auxiliary control bits not zero");

  AST_PEND_READ: assert property (
    s_rd(`SCR_OFS_INTERRUPT_CONTROL_STATE) |=> o_hrdata[`SCR_INTERRUPT_CONTROL_STATE_NMI_SET] == o_nmi_pending
      && o_hrdata[`SCR_INTERRUPT_CONTROL_STATE_TCK_SET] == o_tick_pending[$past(i_hnonsec)])
    else $error("pending bits read back wrong");

endmodule

// ===== system_control_regs_tb.sv
`timescale 1ns/1ps
`include "scr_map.svh"

module system_control_regs_tb;
  import scr_pkg::*;

  // ------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------
  localparam logic [7:0]  IMPL    = 8'ha7;   // arbitrary value
  localparam logic [3:0]  VARI    = 4'h6;    // arbitrary value
  localparam logic [11:0] PART    = 12'h9b4; // arbitrary value
  localparam logic [3:0]  PTCH    = 4'hc;    // arbitrary value
  localparam logic [11:0] OFS_ICS = 12'h004;

  logic      i_clk, i_rst_b, i_hsel, i_hwrite, i_hnonsec;
  logic      i_nmi_req, i_nmi_taken, i_preempted_active, i_isr_pending;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  wire logic i_hready;
  scr_word_t i_haddr, i_hwdata, o_hrdata, rnd, m_aux;
  scr_bank_t i_svc_taken, i_tick_req, i_tick_taken, o_service_call_pending, o_tick_pending;
  scr_bank_t m_svc, m_tick;
  scr_vec_t  i_active_vector, i_pending_vector;
  scr_evt_t  m_stat, m_en;
  logic      o_hreadyout, o_hresp, o_fp_out_of_order_disable, o_dual_issue_disable;
  logic      o_multicycle_interrupt_disable, o_nmi_pending, o_irq, m_nmi, sel;
  int        seed, n_mismatch, checked, b, k;

  // the only slave drives the bus ready
  assign i_hready = o_hreadyout;

  scr_top #(.IMPLEMENTER(IMPL), .VARIANT(VARI), .PART_NUMBER(PART), .PATCH(PTCH)) dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .i_hnonsec(i_hnonsec), .i_nmi_req(i_nmi_req),
    .i_nmi_taken(i_nmi_taken), .i_svc_taken(i_svc_taken), .i_tick_req(i_tick_req),
    .i_tick_taken(i_tick_taken), .i_active_vector(i_active_vector),
    .i_pending_vector(i_pending_vector), .i_preempted_active(i_preempted_active),
    .i_isr_pending(i_isr_pending), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_fp_out_of_order_disable(o_fp_out_of_order_disable),
    .o_dual_issue_disable(o_dual_issue_disable),
    .o_multicycle_interrupt_disable(o_multicycle_interrupt_disable),
    .o_nmi_pending(o_nmi_pending), .o_service_call_pending(o_service_call_pending),
    .o_tick_pending(o_tick_pending), .o_irq(o_irq));

  // ------------------------------------------------------------
  // bus, model and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input scr_word_t seen, input scr_word_t exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // address phase held until ready, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [11:0] a, input scr_word_t d, input logic ns,
                     output scr_word_t q);
    i_hsel    <= sel;
    i_haddr   <= {20'h0, a};
    i_htrans  <= 2'b10;
    i_hwrite  <= w;
    i_hnonsec <= ns;
    @(posedge i_clk);
    while (i_hready !== 1'b1) @(posedge i_clk);
    i_htrans <= 2'b00;
    i_hwdata <= d;
    @(posedge i_clk);
    while (i_hready !== 1'b1) @(posedge i_clk);
    q = o_hrdata;
  endtask

  // set wins over clear; a status event only on a fresh pending edge
  task automatic m_upd(input logic ns, nc, input scr_bank_t ss, sc, ts, tc);
    m_stat = m_stat | {|(ts & ~m_tick), |(ss & ~m_svc), ns & ~m_nmi};
    m_nmi  = ns | (m_nmi & ~nc);
    m_svc  = ss | (m_svc & ~sc);
    m_tick = ts | (m_tick & ~tc);
  endtask

  function automatic scr_word_t exp_rd(input logic [11:0] a, input logic ns);
    case (a)
      `SCR_OFS_IDENT:    return {IMPL, VARI, 4'hf, PART, PTCH};
      OFS_ICS:           return {m_nmi, 2'b00, m_svc[ns], 1'b0, m_tick[ns], 3'b000,
                                 i_isr_pending, 1'b0, i_pending_vector, ~i_preempted_active,
                                 2'b00, i_active_vector};
      `SCR_OFS_AUX:      return m_aux;
      `SCR_OFS_IRQ_STAT: return {29'h0, m_stat};
      `SCR_OFS_IRQ_EN:   return {29'h0, m_en};
      default:           return 32'h0;
    endcase
  endfunction

  task automatic wr(input logic [11:0] a, input scr_word_t d, input logic ns);
    scr_word_t q;
    scr_bank_t s;
    s = ns ? 2'b10 : 2'b01;
    bus(1'b1, a, d, ns, q);
    if (sel) case (a)
      `SCR_OFS_AUX:     m_aux = d & 32'h0000_0205;
      OFS_ICS:          m_upd(d[31], d[30], s & {2{d[28]}}, s & {2{d[27]}},
                              s & {2{d[26]}}, s & {2{d[25]}});
      `SCR_OFS_IRQ_CLR: m_stat = m_stat & ~d[2:0];
      `SCR_OFS_IRQ_EN:  m_en = d[2:0];
      default: ;
    endcase
  endtask

  task automatic rdc(input logic [11:0] a, input logic ns);
    scr_word_t q;
    rnd = $random(seed);
    bus(1'b0, a, rnd, ns, q);
    chk(q, sel ? exp_rd(a, ns) : 32'h0000_0000);
  endtask

  // levels are given two spare cycles, the irq path may hold one more register
  task automatic outs;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk({21'h0, o_irq, o_tick_pending, o_service_call_pending, o_nmi_pending,
         o_fp_out_of_order_disable, o_dual_issue_disable, o_multicycle_interrupt_disable,
         o_hresp, o_hreadyout},
        {21'h0, |(m_stat & m_en), m_tick, m_svc, m_nmi, m_aux[9], m_aux[2], m_aux[0],
         2'b01});
    @(posedge i_clk);
  endtask

  task automatic core(input logic nr, nt, input scr_bank_t st, tr, tt);
    i_nmi_req    <= nr;
    i_nmi_taken  <= nt;
    i_svc_taken  <= st;
    i_tick_req   <= tr;
    i_tick_taken <= tt;
    @(posedge i_clk);
    {i_nmi_req, i_nmi_taken, i_svc_taken, i_tick_req, i_tick_taken} <= 8'h00;
    m_upd(nr, nt, 2'b00, st, tr, tt);
    outs;
  endtask

  task automatic do_reset;
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    {m_aux, m_nmi, m_svc, m_tick, m_stat, m_en} = 43'h0;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    #400000;
    n_mismatch++;
    test_done;
  end

  initial begin
    seed = 32'h01f60d49;
    {i_rst_b, i_hsel, i_hwrite, i_hnonsec, i_nmi_req, i_nmi_taken} = 6'h0;
    {i_htrans, i_haddr, i_hwdata, i_svc_taken, i_tick_req, i_tick_taken} = 72'h0;
    {i_active_vector, i_pending_vector, i_preempted_active, i_isr_pending} = 20'h0;
    i_hsize = 3'h2;
    sel     = 1'b1;
    do_reset;
    outs;
    for (b = 0; b < 2; b++) begin
      rdc(`SCR_OFS_IDENT, b[0]);
      rdc(`SCR_OFS_AUX, b[0]);
    end
    wr(`SCR_OFS_IDENT, 32'hffff_ffff, 1'b0);
    rdc(`SCR_OFS_IDENT, 1'b0);
    wr(12'h00c, 32'hffff_ffff, 1'b0);
    rdc(12'h00c, 1'b0);
    for (k = 0; k < 8; k++) begin
      rnd = $random(seed);
      wr(`SCR_OFS_AUX, k == 0 ? 32'hffff_ffff : rnd, k[0]);
      outs;
      rdc(`SCR_OFS_AUX, ~k[0]);
    end
    // a transfer without select must leave every control bit alone
    sel = 1'b0;
    wr(`SCR_OFS_AUX, m_aux ^ 32'h0000_0205, 1'b0);
    rdc(`SCR_OFS_AUX, 1'b0);
    sel = 1'b1;
    outs;
    rdc(`SCR_OFS_AUX, 1'b0);
    wr(OFS_ICS, 32'h8000_0000, 1'b0);
    rdc(OFS_ICS, 1'b1);
    wr(OFS_ICS, 32'h0000_0000, 1'b0);
    rdc(OFS_ICS, 1'b0);
    wr(OFS_ICS, 32'h4000_0000, 1'b1);
    outs;
    wr(OFS_ICS, 32'hc000_0000, 1'b0);
    rdc(OFS_ICS, 1'b0);
    for (b = 0; b < 2; b++) begin
      wr(OFS_ICS, 32'h1400_0000, b[0]);
      rdc(OFS_ICS, b[0]);
      rdc(OFS_ICS, ~b[0]);
      wr(OFS_ICS, 32'h0800_0000, b[0]);
      outs;
      wr(OFS_ICS, 32'h0200_0000, b[0]);
      rdc(OFS_ICS, b[0]);
    end
    for (k = 0; k < 12; k++) begin
      rnd = $random(seed);
      i_active_vector    <= rnd[8:0];
      i_pending_vector   <= rnd[17:9];
      i_preempted_active <= rnd[18];
      i_isr_pending      <= rnd[19];
      core(rnd[20], rnd[21], rnd[23:22], rnd[25:24], rnd[27:26]);
      rnd = $random(seed);
      wr(OFS_ICS, rnd, k[0]);
      rdc(OFS_ICS, k[1]);
    end
    wr(`SCR_OFS_IRQ_EN, 32'hffff_ffff, 1'b0);
    rdc(`SCR_OFS_IRQ_EN, 1'b0);
    wr(`SCR_OFS_IRQ_STAT, 32'h0000_0000, 1'b0);
    wr(`SCR_OFS_IRQ_CLR, 32'h0000_0007, 1'b0);
    rdc(`SCR_OFS_IRQ_STAT, 1'b0);
    for (k = 0; k < 10; k++) begin
      rnd = $random(seed);
      wr(`SCR_OFS_IRQ_EN, rnd, 1'b0);
      core(rnd[3], rnd[4], rnd[6:5], rnd[8:7], rnd[10:9]);
      rdc(`SCR_OFS_IRQ_STAT, 1'b0);
      wr(`SCR_OFS_IRQ_CLR, {29'h0, rnd[13:11]}, 1'b0);
      outs;
    end
    do_reset;
    outs;
    rdc(`SCR_OFS_AUX, 1'b0);
    rdc(OFS_ICS, 1'b1);
    test_done;
  end
endmodule
